// ==== core/ccu_cmd_decode.sv ====
// command decoder: classifies a channel command for the attached device
// assumes the command byte is held stable by the control unit core
`timescale 1ns/1ps
`default_nettype none
module ccu_cmd_decode
  import ccu_pkg::*;
(
  ccu_cmd_if.dec cmd
);

  // ****************************************
  // decode
  // ****************************************
  // low bits pick the operation, upper bits go to the device as modifiers
  always_comb begin
    cmd.modifier = cmd.cmd_byte[7:2];
    if (cmd.cmd_byte == BYTE_ZERO) begin
      cmd.op = OP_NONE;                   // zero is not a command here
    end else begin
      case (cmd.cmd_byte[1:0])
        CMD_WRITE: cmd.op = OP_WRITE;
        CMD_READ:  cmd.op = OP_READ;
        CMD_CTRL:  cmd.op = OP_CONTROL;
        default: begin
          // sense keeps its low four bits fixed, other patterns are rejected
          if (cmd.cmd_byte[3:0] == CMD_SENSE) begin
            cmd.op = OP_SENSE;
          end else begin
            cmd.op = OP_NONE;
          end
        end
      endcase
    end
  end

endmodule // ccu_cmd_decode
`default_nettype wire

// ==== core/ccu_cmd_if.sv ====
// carries the latched command byte to the decoder and its verdict back
// assumes one driver on each side, all on the control unit clock
`timescale 1ns/1ps
`default_nettype none
interface ccu_cmd_if;
  import ccu_pkg::*;
  logic [7:0] cmd_byte;
  ccu_op_e    op;
  logic [5:0] modifier;
  modport ctrl (output cmd_byte, input op, input modifier);
  modport dec  (input cmd_byte, output op, output modifier);
endinterface
`default_nettype wire

// ==== core/ccu_ctrl_unit.sv ====
// control unit end of the channel parallel i/o interface, with device-side strobes
// assumes channel pins are asynchronous and the channel keeps its own interlock duties
//
// Overview of operation
// [RQ1] all traffic shares one set of lines
// [RQ2] every tag change waits for its answer
// [RQ3] data, status, sense, control, addresses both ways
// [RQ4] burst runs unbroken until device or channel ends
// [RQ5] multiplex disconnects between bytes, reselects on request
// [RQ6] same formats and interlocks in both modes
// [RQ7] channel bursts only when unit holds connection
// [RQ8] decode command, drive device-specific sequence
// [RQ9] channel outputs reach every unit together
// [RQ10] only connected unit drives inbound lines; req_in and sel_fwd are still driven while opl_in is low
// [RQ11] channel steers transfers to main storage
// [RQ12] nine-line bytes, position 0 high, odd parity
// [RQ13] channel leads tags with stable bus data
// [RQ14] up to 256 device addresses
// [RQ15] stay connected until done or told off
// [RQ16] reset returns idle, tags down, disconnected
`timescale 1ns/1ps
`default_nettype none
module ccu_ctrl_unit
  import ccu_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_out_par,
  input  wire logic       adr_out,
  input  wire logic       cmd_out,
  input  wire logic       srv_out,
  input  wire logic       opl_out,
  input  wire logic       hld_out,
  input  wire logic       sel_out,
  input  wire logic       sup_out,
  output logic      [7:0] bus_in,
  output logic            bus_in_par,
  output logic            adr_in,
  output logic            sta_in,
  output logic            srv_in,
  output logic            opl_in,
  output logic            req_in,
  output logic            sel_fwd,
  output logic            inbound_oe,
  output logic            dev_start,
  output ccu_op_e         dev_op,
  output logic      [5:0] dev_mod,
  output logic      [7:0] wr_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_take,
  input  wire logic       dev_done,
  input  wire logic [7:0] dev_status,
  input  wire logic       dev_burst
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [IN_W-1:0] pins_meta;
  logic [IN_W-1:0] pins_sync;
  logic [IN_W-1:0] pins_prev;
  logic            adr_t, cmd_t, srv_t, opl_t, sel_t, sup_t;
  logic [7:0]      bus_s;
  logic            par_ok, addr_hit, cmd_rise, srv_rise, sel_rise;

  // two stages on every channel line; tags and data share the same delay
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pins_meta <= '0;
      pins_sync <= '0;
      pins_prev <= '0;
    end else begin
      pins_meta <= {bus_out_par, bus_out, sup_out, sel_out, hld_out, opl_out, srv_out, cmd_out, adr_out};
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  assign adr_t    = pins_sync[TG_ADR];
  assign cmd_t    = pins_sync[TG_CMD];
  assign srv_t    = pins_sync[TG_SRV];
  assign opl_t    = pins_sync[TG_OPL];
  assign sel_t    = pins_sync[TG_SEL] & pins_sync[TG_HLD];
  assign sup_t    = pins_sync[TG_SUP];
  assign bus_s    = pins_sync[BUS_LSB +: BYTE_W];
  assign par_ok   = pins_sync[PAR_BIT] == odd_par(bus_s);                          // RQ12
  assign cmd_rise = cmd_t & ~pins_prev[TG_CMD];
  assign srv_rise = srv_t & ~pins_prev[TG_SRV];
  assign sel_rise = sel_t & ~(pins_prev[TG_SEL] & pins_prev[TG_HLD]);
  // every unit sees the same address byte; only a full match claims it
  assign addr_hit = adr_t & par_ok & (bus_s == DEV_ADDR);                          // RQ9 RQ14

  // ****************************************
  // command decode
  // ****************************************
  ccu_cmd_if  cmd_if ();
  logic [7:0] cmd_reg;
  logic       cmd_par_bad, reject, stop, uc_flag, rej_flag, chk_flag;
  logic       want_bus, tags_low;
  ccu_state_e state;

  assign cmd_if.cmd_byte = cmd_reg;
  assign reject   = cmd_par_bad | (cmd_if.op == OP_NONE);
  assign tags_low = ~srv_t & ~cmd_t;
  // device ready for the next byte, or ending, counts as a reason to reconnect
  assign want_bus = dev_done | (dev_op == OP_SENSE) | ((dev_op == OP_READ) & rd_valid) |
                    ((dev_op == OP_WRITE) & wr_ready);

  ccu_cmd_decode u_decode (
    .cmd (cmd_if.dec)
  );

  // ****************************************
  // sequence controller
  // ****************************************
  // channel dropping operational out ends any connection at once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;                                                            // RQ16
    end else if (!opl_t) begin
      state <= ST_IDLE;                                                            // RQ15 RQ16
    end else begin
      case (state)
        ST_IDLE:     if (sel_rise && addr_hit) state <= ST_SEL_ADR;
        ST_SEL_ADR:  if (cmd_rise) state <= ST_SEL_CMD;                            // RQ2
        ST_SEL_CMD:  if (!cmd_t) state <= ST_INIT_ST;
        ST_INIT_ST:  if (srv_rise || cmd_rise) state <= ST_INIT_DN;                // RQ2
        ST_INIT_DN: begin
          if (tags_low) begin
            if (reject) state <= ST_IDLE;
            else if (dev_op == OP_CONTROL) state <= ST_END_ST;
            else state <= ST_WAIT_DEV;
          end
        end
        ST_WAIT_DEV: begin
          if (dev_done) state <= ST_END_ST;
          else if (want_bus) state <= ST_XFER_UP;
        end
        ST_XFER_UP:  if (srv_rise || cmd_rise) state <= ST_XFER_DN;                // RQ2
        ST_XFER_DN: begin
          if (tags_low) begin
            // same byte exchange either way; only the reconnect differs
            if (stop || dev_op == OP_SENSE) state <= ST_END_ST;                    // RQ4
            else if (dev_burst) state <= ST_WAIT_DEV;                              // RQ4 RQ6 RQ7
            else state <= ST_DISC;                                                 // RQ5 RQ6
          end
        end
        ST_DISC:     if (sel_rise && req_in && !adr_t) state <= ST_RESEL;          // RQ5
        ST_RESEL:    if (cmd_rise) state <= ST_RESEL_DN;                           // RQ2
        ST_RESEL_DN: if (!cmd_t) state <= ST_WAIT_DEV;
        ST_END_ST:   if (srv_rise || cmd_rise) state <= ST_END_DN;
        ST_END_DN:   if (tags_low) state <= ST_IDLE;
        default:     state <= ST_IDLE;
      endcase
    end
  end

  // inbound tags other than request in decode straight from the state flops
  assign opl_in     = (state != ST_IDLE) && (state != ST_DISC);                    // RQ10
  assign adr_in     = (state == ST_SEL_ADR) || (state == ST_RESEL);
  assign sta_in     = (state == ST_INIT_ST) || (state == ST_END_ST);
  assign srv_in     = state == ST_XFER_UP;
  assign inbound_oe = opl_in;                                                      // RQ10
  // suppress out holds back new requests without losing them
  assign req_in     = (state == ST_DISC) & want_bus & ~sup_t;

  // ****************************************
  // bus in byte
  // ****************************************
  // loaded on the edge that raises the tag, held until that tag drops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {bus_in_par, bus_in} <= with_par(BYTE_ZERO);
    end else begin
      case (state)
        ST_IDLE, ST_DISC: {bus_in_par, bus_in} <= with_par(DEV_ADDR);              // RQ1
        ST_SEL_CMD: {bus_in_par, bus_in} <= with_par(reject ? (ST_UC_M | ST_CE_M | ST_DE_M) : BYTE_ZERO);
        ST_INIT_DN, ST_XFER_DN: {bus_in_par, bus_in} <= with_par(dev_status | ST_CE_M | ST_DE_M |
                                                                  (uc_flag ? ST_UC_M : BYTE_ZERO));
        ST_WAIT_DEV: begin
          if (dev_done) begin
            {bus_in_par, bus_in} <= with_par(dev_status | ST_CE_M | ST_DE_M | (uc_flag ? ST_UC_M : BYTE_ZERO));
          end else if (dev_op == OP_SENSE) begin
            {bus_in_par, bus_in} <= with_par((rej_flag ? SN_CMD_REJ_M : BYTE_ZERO) |
                                             (chk_flag ? SN_BUS_CHK_M : BYTE_ZERO)); // RQ3
          end else if (dev_op == OP_READ && rd_valid) begin
            {bus_in_par, bus_in} <= with_par(rd_data);                             // RQ12
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // command capture and device strobes
  // ****************************************
  // bus out is sampled on the synchronised tag rise; the channel lead covers skew
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg     <= BYTE_ZERO;
      cmd_par_bad <= 1'b0;
      dev_op      <= OP_NONE;
      dev_mod     <= '0;
      dev_start   <= 1'b0;
      wr_data     <= BYTE_ZERO;
      wr_valid    <= 1'b0;
      rd_take     <= 1'b0;
    end else begin
      dev_start <= (state == ST_INIT_DN) && tags_low && !reject && opl_t;          // RQ8
      wr_valid  <= (state == ST_XFER_UP) && srv_rise && (dev_op == OP_WRITE);
      rd_take   <= (state == ST_WAIT_DEV) && !dev_done && (dev_op == OP_READ) && rd_valid;
      if (state == ST_SEL_ADR && cmd_rise) begin
        cmd_reg     <= bus_s;                                                      // RQ13
        cmd_par_bad <= !par_ok;
      end
      if (state == ST_SEL_CMD && !cmd_t) begin
        dev_op  <= reject ? OP_NONE : cmd_if.op;                                   // RQ8
        dev_mod <= cmd_if.modifier;
      end
      if (state == ST_XFER_UP && srv_rise && dev_op == OP_WRITE) begin
        wr_data <= bus_s;                                                          // RQ3 RQ13
      end
    end
  end

  // ****************************************
  // check flags and forwarding
  // ****************************************
  // sense flags clear after a sense completes; a new error in that cycle still sets
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stop     <= 1'b0;
      uc_flag  <= 1'b0;
      rej_flag <= 1'b0;
      chk_flag <= 1'b0;
      sel_fwd  <= 1'b0;
    end else begin
      if (state == ST_IDLE) stop <= 1'b0;
      else if (state == ST_XFER_UP && cmd_rise) stop <= 1'b1;                      // RQ4
      if (state == ST_SEL_CMD && !cmd_t && reject) uc_flag <= 1'b1;
      else if (state == ST_XFER_UP && srv_rise && dev_op == OP_WRITE && !par_ok) uc_flag <= 1'b1;
      else if (state == ST_IDLE) uc_flag <= 1'b0;
      if (state == ST_SEL_CMD && !cmd_t && reject) rej_flag <= 1'b1;
      else if (state == ST_END_DN && tags_low && dev_op == OP_SENSE) rej_flag <= 1'b0;
      if ((state == ST_SEL_CMD && !cmd_t && cmd_par_bad) ||
          (state == ST_XFER_UP && srv_rise && dev_op == OP_WRITE && !par_ok)) chk_flag <= 1'b1;
      else if (state == ST_END_DN && tags_low && dev_op == OP_SENSE) chk_flag <= 1'b0;
      // pass select down the chain unless this unit claims it
      sel_fwd <= sel_t & ~(opl_in | ((state == ST_IDLE) & addr_hit & opl_t) | req_in); // RQ10
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_tags_need_opl:   assert property ((adr_in || sta_in || srv_in) |-> opl_in && inbound_oe) // RQ10
    else $error("inbound tag up while not connected");
  chk_bus_in_parity:   assert property (inbound_oe |-> ^{bus_in_par, bus_in})    // RQ12
    else $error("bus in byte without odd parity");
  chk_srv_interlock:   assert property (srv_in && !srv_t && !cmd_t && opl_t |=> srv_in) // RQ2
    else $error("service in dropped without response");
  chk_sta_interlock:   assert property (sta_in && !srv_t && !cmd_t && opl_t |=> sta_in) // RQ2
    else $error("status in dropped without response");
  chk_reset_idle:      assert property (!opl_t |=> !opl_in && !srv_in && !sta_in) // RQ16 RQ15
    else $error("still connected after operational out dropped");
  chk_addr_echo:       assert property (adr_in |-> bus_in == DEV_ADDR)           // RQ14
    else $error("address in without own address");
  chk_write_strobe:    assert property (wr_valid |-> $past(srv_t) && $past(srv_in) && dev_op == OP_WRITE) // RQ3
    else $error("write strobe without service exchange");
  chk_mux_disconnect:  assert property (state == ST_XFER_DN && tags_low && opl_t && !dev_burst && !stop &&
                                        dev_op != OP_SENSE |=> !opl_in ##1 !opl_in) // RQ5
    else $error("multiplex unit stayed connected after byte");
  chk_burst_hold:      assert property (state == ST_XFER_DN && tags_low && opl_t && dev_burst && !stop &&
                                        dev_op != OP_SENSE |=> opl_in)             // RQ4
    else $error("burst unit dropped connection mid transfer");
  chk_start_decoded:   assert property (dev_start |-> dev_op != OP_NONE && $past(state, 2) != ST_IDLE) // RQ8
    else $error("device start without decoded command");

  cov_burst_read:  cover property (dev_burst && rd_take ##[1:20] srv_in);
  cov_reselect:    cover property (state == ST_DISC ##[1:50] state == ST_RESEL);
  cov_write_byte:  cover property (wr_valid);
  cov_chan_stop:   cover property (srv_in && cmd_rise);

endmodule // ccu_ctrl_unit
`default_nettype wire

// ==== core/ccu_pkg.sv ====
// constants, types and helpers shared by the control unit core and its decoder
// assumes an 8-bit byte bus with one odd parity line in each direction
package ccu_pkg;

  // ****************************************
  // bus and pin layout
  // ****************************************
  localparam int BYTE_W  = 8;
  localparam int TG_ADR  = 0;            // address out tag
  localparam int TG_CMD  = 1;            // command out tag
  localparam int TG_SRV  = 2;            // service out tag
  localparam int TG_OPL  = 3;            // operational out
  localparam int TG_HLD  = 4;            // hold out
  localparam int TG_SEL  = 5;            // select out
  localparam int TG_SUP  = 6;            // suppress out
  localparam int BUS_LSB = 7;            // bus out byte starts here
  localparam int PAR_BIT = 15;           // bus out parity
  localparam int IN_W    = 16;           // all synchronised inbound pins

  // default device address, one of 256 on the channel
  localparam logic [7:0] DEV_ADDR_DEF = 8'h10;

  // ****************************************
  // status and sense bytes (vector bit 7 is bus position 0)
  // ****************************************
  localparam logic [7:0] ST_UC_M       = 8'h02;  // unit check, position 6
  localparam logic [7:0] ST_DE_M       = 8'h04;  // device end, position 5
  localparam logic [7:0] ST_CE_M       = 8'h08;  // channel end, position 4
  localparam logic [7:0] SN_CMD_REJ_M  = 8'h80;  // command reject, position 0
  localparam logic [7:0] SN_BUS_CHK_M  = 8'h40;  // bus out parity check, position 1
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ****************************************
  // command encodings (low-order bits sit in positions 6 and 7)
  // ****************************************
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_CTRL  = 2'h3;
  localparam logic [3:0] CMD_SENSE = 4'h4;

  typedef enum logic [2:0] {OP_NONE, OP_WRITE, OP_READ, OP_CONTROL, OP_SENSE} ccu_op_e;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEL_ADR, ST_SEL_CMD, ST_INIT_ST, ST_INIT_DN, ST_WAIT_DEV,
    ST_XFER_UP, ST_XFER_DN, ST_DISC, ST_RESEL, ST_RESEL_DN, ST_END_ST, ST_END_DN
  } ccu_state_e;

  // parity bit that makes the nine lines odd
  function automatic logic odd_par(input logic [7:0] b);
    return ~(^b);
  endfunction

  // byte with its parity bit on top
  function automatic logic [8:0] with_par(input logic [7:0] b);
    return {odd_par(b), b};
  endfunction

endpackage

// ==== tb/ccu_chan_model.sv ====
// channel model: drives bus out and the outbound tags, answers inbound tags
// assumes the unit clock paces it; pins change only after falling edges
`timescale 1ns/1ps
`default_nettype none
module ccu_chan_model (
  input  wire logic       clock,
  input  wire logic [7:0] bus_in,
  input  wire logic       bus_in_par,
  input  wire logic       adr_in,
  input  wire logic       sta_in,
  input  wire logic       srv_in,
  input  wire logic       opl_in,
  input  wire logic       req_in,
  input  wire logic       sel_fwd,
  output logic      [7:0] bus_out,
  output logic            bus_out_par,
  output logic            adr_out,
  output logic            cmd_out,
  output logic            srv_out,
  output logic            opl_out,
  output logic            hld_out,
  output logic            sel_out,
  output logic            sup_out
);
  int         n_to  = 0;  // waits that ran out
  int         n_par = 0;  // inbound bytes with even parity
  logic [7:0] abyte;      // byte shown with address in
  logic       rsel = 1'b0; // select out alone, answering request in
  logic       stp  = 1'b0; // stop: command out answers service in
  logic [4:0] itag;
  assign itag = {req_in, opl_in, srv_in, sta_in, adr_in};

  // idle channel, every tag down
  initial begin
    {adr_out, cmd_out, srv_out, opl_out, hld_out, sel_out, sup_out} = 7'h00;
    {bus_out_par, bus_out} = 9'h100;
  end

  // byte onto the shared bus, three cycles (150 ns) ahead of its tag
  task automatic put(input logic [7:0] b, input logic good);
    {bus_out_par, bus_out} = {(^b) ^ good, b};
    repeat (3) @(negedge clock);
  endtask

  // bounded wait for inbound tag i to reach level v
  task automatic wt(input int i, input logic v);
    int k;
    for (k = 0; k < 400 && itag[i] !== v; k++) @(negedge clock);
    if (itag[i] !== v) n_to++;
  endtask

  // select a device; a refused address leaves address in down
  task automatic sel(input logic [7:0] a, input logic good, output logic got, output logic fwd);
    int k;
    fwd = 1'b0;
    opl_out = 1'b1;
    put(a, good);
    adr_out = !rsel; // reselect carries no address out
    repeat (2) @(negedge clock);
    {sel_out, hld_out} = 2'h3;
    for (k = 0; k < 20 && adr_in !== 1'b1; k++) begin
      @(negedge clock);
      fwd |= (sel_fwd === 1'b1);
    end
    got = (adr_in === 1'b1);
    abyte = bus_in;
    n_par += (got && bus_in_par !== ~^bus_in);
    {adr_out, sel_out, hld_out} = 3'h0;
    {bus_out_par, bus_out} = ~{bus_out_par, bus_out};
  endtask

  // command out, held until address in falls (reselect answers after the fall)
  task automatic cmd(input logic [7:0] c, input logic good);
    int k;
    put(c, good);
    cmd_out = 1'b1;
    for (k = 0; k < 10 && adr_in !== 1'b0; k++) @(negedge clock);
    cmd_out = 1'b0;
    wt(0, 1'b0);
    {bus_out_par, bus_out} = ~{bus_out_par, bus_out};
  endtask

  // one service exchange; kind is {status in, service in}
  task automatic xfer(input logic [7:0] wb, output logic [1:0] kind, output logic [7:0] rb);
    int k;
    for (k = 0; k < 400 && srv_in !== 1'b1 && sta_in !== 1'b1; k++) @(negedge clock);
    kind = {sta_in === 1'b1, srv_in === 1'b1};
    n_to += (kind == 2'h0);
    rb = bus_in;
    n_par += (bus_in_par !== ~^bus_in);
    put(wb, 1'b1);
    {cmd_out, srv_out} = {stp, !stp};
    wt(1, 1'b0);
    wt(2, 1'b0);
    {cmd_out, srv_out} = 2'h0;
    {bus_out_par, bus_out} = ~{bus_out_par, bus_out};
  endtask
endmodule // ccu_chan_model
`default_nettype wire

// ==== tb/testbench.sv ====
// bench for the control unit core: channel model on the link, device side here
// assumes the channel model tasks pace every link handshake
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccu_pkg::*;
  localparam logic [1:0] K_SRV  = 2'h1;
  localparam logic [1:0] K_STA  = 2'h2;
  localparam logic [7:0] ST_END = ST_CE_M | ST_DE_M;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] bus_out, bus_in, wr_data, rd_data, dev_status;
  logic       bus_out_par, adr_out, cmd_out, srv_out, opl_out, hld_out, sel_out, sup_out;
  logic       bus_in_par, adr_in, sta_in, srv_in, opl_in, req_in, sel_fwd, inbound_oe;
  logic       dev_start, wr_valid, rd_take, wr_ready, rd_valid, dev_done, dev_burst, done_arm;
  ccu_op_e    dev_op, last_op;
  logic [5:0] dev_mod, last_mod;
  logic [7:0] rd_q[$], wr_got[$];
  int         wr_want = 0, n_start = 0, n_fail = 0, checked = 0;

  always #25 clock = ~clock; // 50 ns period

  ccu_ctrl_unit #(.DEV_ADDR(DEV_ADDR_DEF)) DUT (.clock, .rst_b, .bus_out, .bus_out_par, .adr_out,
    .cmd_out, .srv_out, .opl_out, .hld_out, .sel_out, .sup_out, .bus_in, .bus_in_par, .adr_in,
    .sta_in, .srv_in, .opl_in, .req_in, .sel_fwd, .inbound_oe, .dev_start, .dev_op, .dev_mod,
    .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_take, .dev_done, .dev_status, .dev_burst);
  ccu_chan_model chan (.clock, .bus_in, .bus_in_par, .adr_in, .sta_in, .srv_in, .opl_in, .req_in,
    .sel_fwd, .bus_out, .bus_out_par, .adr_out, .cmd_out, .srv_out, .opl_out, .hld_out, .sel_out, .sup_out);

  // device: queued read bytes, collected writes, done once drained
  always @(negedge clock) begin
    if (wr_valid === 1'b1) wr_got.push_back(wr_data);
    if (rd_take === 1'b1 && rd_q.size() > 0) void'(rd_q.pop_front());
    if (dev_start === 1'b1) begin
      n_start++;
      last_op = dev_op;
      last_mod = dev_mod;
    end
    rd_valid = rd_q.size() > 0;
    rd_data = rd_valid ? rd_q[0] : ~rd_data; // idle data never looks stale
    wr_ready = wr_got.size() < wr_want;
    dev_done = done_arm && !rd_valid && wr_got.size() >= wr_want;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a wait that ran out ends the run at the guard call after its test
  task automatic guard();
    if (chan.n_to != 0) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic exch(input logic [7:0] wb, input logic [1:0] ek, input logic ck, input logic [7:0] eb);
    logic [1:0] kd;
    logic [7:0] rb;
    chan.xfer(wb, kd, rb);
    chk({6'h00, kd}, {6'h00, ek});
    if (ck) chk(rb, eb);
  endtask

  task automatic open_op(input logic [7:0] c, input logic good);
    logic got, fwd;
    chan.sel(DEV_ADDR_DEF, 1'b1, got, fwd);
    chk({6'h00, got, fwd}, 8'h02);
    chk(chan.abyte, DEV_ADDR_DEF);
    chan.cmd(c, good);
  endtask

  task automatic close_op(input logic [7:0] es);
    exch(8'h00, K_STA, 1'b1, es);
    chan.wt(3, 1'b0);
  endtask

  task automatic t_reset();
    chk({opl_in, adr_in, sta_in, srv_in, req_in, sel_fwd, inbound_oe, dev_start}, 8'h00);
    chk({5'h00, dev_op}, {5'h00, OP_NONE});
  endtask

  task automatic t_other_addr();
    logic got, fwd;
    chan.sel(DEV_ADDR_DEF ^ 8'h01, 1'b1, got, fwd);
    chk({6'h00, got, fwd}, 8'h01);
    chan.sel(DEV_ADDR_DEF, 1'b0, got, fwd);
    chk({6'h00, got, fwd}, 8'h01);
  endtask

  task automatic t_write_burst();
    wr_got.delete();
    {wr_want, dev_status, dev_burst, done_arm} = {32'd2, 8'h20, 2'h3};
    open_op({6'h29, CMD_WRITE}, 1'b1);
    exch(8'h00, K_STA, 1'b1, 8'h00);
    exch(8'h3C, K_SRV, 1'b0, 8'h00);
    exch(8'hC3, K_SRV, 1'b0, 8'h00);
    close_op(8'h20 | ST_END);
    chk(wr_got[0], 8'h3C);
    chk(wr_got[1], 8'hC3);
    chk({2'h0, last_mod}, 8'h29);
    chk({5'h00, last_op}, {5'h00, OP_WRITE});
    {dev_status, done_arm} = 9'h000;
  endtask

  // multiplex read: disconnect after each byte, reselect on request in
  task automatic t_read_mplx();
    int r;
    rd_q = '{8'hA5, 8'h3C};
    {wr_want, dev_burst, done_arm} = {32'd0, 2'h1};
    open_op({6'h00, CMD_READ}, 1'b1);
    exch(8'h00, K_STA, 1'b1, 8'h00);
    for (r = 0; r < 3; r++) begin
      if (r > 0) begin
        chan.wt(4, 1'b1);
        chan.rsel = 1'b1;
        open_op(8'h00, 1'b1);
        chan.rsel = 1'b0;
      end
      if (r == 2) close_op(ST_END);
      else begin
        exch(8'h00, K_SRV, 1'b1, (r == 0) ? 8'hA5 : 8'h3C);
        chan.wt(3, 1'b0);
      end
    end
    chk({5'h00, last_op}, {5'h00, OP_READ});
    {dev_burst, done_arm} = 2'h2;
  endtask

  task automatic t_cmd_codes();
    int i;
    int n0;
    n0 = n_start;
    for (i = 0; i < 2; i++) begin
      open_op((i == 0) ? 8'h00 : 8'h08, 1'b1);
      close_op(ST_UC_M | ST_END);
    end
    chk(8'(n_start - n0), 8'h00);
    for (i = 0; i < 2; i++) begin
      open_op({4'h0, CMD_SENSE}, 1'b1);
      exch(8'h00, K_STA, 1'b1, 8'h00);
      exch(8'h00, K_SRV, 1'b1, (i == 0) ? SN_CMD_REJ_M : BYTE_ZERO);
      close_op(ST_END);
    end
    done_arm = 1'b1;
    open_op({6'h00, CMD_CTRL}, 1'b1);
    exch(8'h00, K_STA, 1'b1, 8'h00);
    close_op(ST_END);
    done_arm = 1'b0;
    open_op({6'h00, CMD_WRITE}, 1'b0);
    close_op(ST_UC_M | ST_END);
    // channel stop: command out answers service in, no byte strobed
    wr_want = 3;
    open_op({6'h00, CMD_WRITE}, 1'b1);
    exch(8'h00, K_STA, 1'b1, 8'h00);
    chan.stp = 1'b1;
    exch(8'h55, K_SRV, 1'b0, 8'h00);
    chan.stp = 1'b0;
    close_op(ST_END);
    chk(8'(wr_got.size()), 8'h02);
  endtask

  // unit waits connected until the channel drops operational out
  task automatic t_opl_drop();
    wr_want = 0;
    open_op({6'h00, CMD_WRITE}, 1'b1);
    exch(8'h00, K_STA, 1'b1, 8'h00);
    repeat (30) @(negedge clock);
    chk({7'h00, opl_in}, 8'h01);
    chan.opl_out = 1'b0;
    repeat (6) @(negedge clock);
    chk({4'h0, opl_in, sta_in, srv_in, inbound_oe}, 8'h00);
  endtask

  initial begin
    {rd_data, dev_status, wr_ready, rd_valid, dev_done, dev_burst, done_arm} = 21'h00008;
    repeat (5) @(negedge clock);
    t_reset();
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    t_reset();
    t_other_addr();
    guard();
    t_write_burst();
    guard();
    t_read_mplx();
    guard();
    t_cmd_codes();
    guard();
    t_opl_drop();
    guard();
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    t_reset();
    chk(8'(chan.n_par), 8'h00);
    print_verdict();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
